// ### design/power_mode_pkg.sv
package power_mode_pkg;
  localparam logic [2:0] RATIO_RESET = 3'h0;
  localparam logic REDUCED_RESET = 1'b0;
  // oscillator start-up delay, in oscillator periods
  localparam int OSC_START_PERIODS = 1024;
  localparam logic [10:0] OSC_START_CYCLES = 11'(OSC_START_PERIODS);
  // extra regulator settle time on wake, in ns
  localparam int REG_SETTLE_NS = 2000;
  localparam int CLK_PERIOD_NS = 20;
  localparam logic [10:0] REG_SETTLE_CYCLES =
    11'((REG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [7:0] PHASE_RESET = 8'h00;
endpackage

// ### design/power_mode_control.sv
`timescale 1ns/1ps
// Functional notes
// - reduced rate runs one cycle in N
// - code 001 runs one, skips three
// - peripheral clock runs at full rate
// - ratio codes 000..111 give 1:2..1:256
// - irq entry copies enable to resume bit
// - recover clear keeps reduced rate in isr
// - recover set clears enable on irq
// - irq return sets enable from resume bit
// - sleep goes full sleep or idle by select
// - sleep entry clears watchdog counter
// - sleep entry clears powerdown, sets expired
// - sleep stops cpu and system clocks
// - sleep holds io drive state
// - reset wakes by reset, others continue
// - enabled irq wakes regardless of global
// - wake runs prefetched, then isr if global
// - every wake clears watchdog counter
// - pending irq with global off makes sleep a no-op
// - late irq completes sleep, wakes at once
// - regulator low-power in sleep, longer wake
// - idle halts cpu, peripherals keep running
// - any irq ends idle, select kept
// - watchdog in idle wakes, not resets
module power_mode_control
  import power_mode_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic sleep_exec_i,
  input wire logic irq_pending_i,
  input wire logic global_irq_enable_i,
  input wire logic irq_entry_i,
  input wire logic irq_return_i,
  input wire logic watchdog_timeout_i,
  input wire logic crystal_mode_i,
  input wire logic ctrl_write_i,
  input wire logic halt_select_wr_i,
  input wire logic reduced_rate_enable_wr_i,
  input wire logic recover_on_irq_wr_i,
  input wire logic resume_slow_on_exit_wr_i,
  input wire logic [2:0] ratio_wr_i,
  input wire logic regulator_lowpower_sel_i,
  input wire logic [7:0] io_drive_i,
  output logic cpu_run_o,
  output logic periph_clk_en_o,
  output logic sys_clk_en_o,
  output logic clock_out_en_o,
  output logic watchdog_clear_o,
  output logic watchdog_reset_o,
  output logic isr_branch_o,
  output logic regulator_lowpower_o,
  output logic [7:0] io_hold_o,
  output logic io_hold_en_o,
  output logic halt_select_o,
  output logic reduced_rate_enable_o,
  output logic recover_on_irq_o,
  output logic resume_slow_on_exit_o,
  output logic [2:0] ratio_o,
  output logic powerdown_flag_o,
  output logic watchdog_expired_flag_o,
  output logic [1:0] mode_o
);

  // ****************************************
  // mode state
  // ****************************************
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SLEEP = 4'h2,
    ST_IDLE = 4'h4,
    ST_WAKE = 4'h8
  } mode_e;

  mode_e state_reg, state_next;
  logic halt_reg, halt_next;
  logic rr_reg, rr_next;
  logic roi_reg, roi_next;
  logic doe_reg, doe_next;
  logic [2:0] ratio_reg, ratio_next;
  logic [7:0] phase_reg, phase_next;
  logic [10:0] wait_reg, wait_next;
  logic pd_reg, pd_next;
  logic to_reg, to_next;
  logic wdclr_reg, wdclr_next;
  logic wdrst_reg, wdrst_next;
  logic isr_reg, isr_next;
  logic isr_pend_reg, isr_pend_next;
  logic [7:0] hold_reg, hold_next;
  logic cpu_reg, cpu_next;
  logic [7:0] ratio_mask;

  // ratio code n gives 1:2^(n+1)
  always_comb
  begin
    ratio_mask = 8'(({1'b0, 8'hFF} >> (3'h7 - ratio_reg)) & 9'h0FF);
  end

  always_comb
  begin
    state_next = state_reg;
    halt_next = halt_reg;
    rr_next = rr_reg;
    roi_next = roi_reg;
    doe_next = doe_reg;
    ratio_next = ratio_reg;
    phase_next = phase_reg + 8'h01;
    wait_next = wait_reg;
    pd_next = pd_reg;
    to_next = to_reg;
    wdclr_next = 1'b0;
    wdrst_next = 1'b0;
    isr_next = 1'b0;
    isr_pend_next = isr_pend_reg;
    hold_next = hold_reg;
    if (ctrl_write_i)
    begin
      halt_next = halt_select_wr_i;
      rr_next = reduced_rate_enable_wr_i;
      roi_next = recover_on_irq_wr_i;
      doe_next = resume_slow_on_exit_wr_i;
      ratio_next = ratio_wr_i;
      phase_next = PHASE_RESET;
    end
    if (irq_entry_i)
    begin
      doe_next = rr_next;
      if (roi_next && rr_next)
        rr_next = 1'b0;
    end
    if (irq_return_i)
    begin
      rr_next = doe_next;
      phase_next = PHASE_RESET;
    end
    case (state_reg)
      ST_RUN:
      begin
        if (watchdog_timeout_i)
          wdrst_next = 1'b1;
        if (sleep_exec_i && !(irq_pending_i && !global_irq_enable_i))
        begin
          // pending irq with global off leaves all unchanged
          wdclr_next = 1'b1;
          pd_next = 1'b0;
          to_next = 1'b1;
          hold_next = io_drive_i;
          state_next = halt_next ? ST_IDLE : ST_SLEEP;
        end
      end
      ST_SLEEP, ST_IDLE:
      begin
        if (irq_pending_i || watchdog_timeout_i)
        begin
          wdclr_next = 1'b1;
          isr_pend_next = irq_pending_i && global_irq_enable_i;
          if (state_reg == ST_SLEEP)
          begin
            wait_next = (crystal_mode_i ? OSC_START_CYCLES : 11'h000)
              + (regulator_lowpower_sel_i ? REG_SETTLE_CYCLES
                 : 11'h000);
            state_next = ST_WAKE;
          end
          else
          begin
            wait_next = 11'h000;
            state_next = ST_WAKE;
          end
        end
      end
      ST_WAKE:
      begin
        if (wait_reg == 11'h000)
        begin
          isr_next = isr_pend_reg;
          isr_pend_next = 1'b0;
          phase_next = PHASE_RESET;
          state_next = ST_RUN;
        end
        else
          wait_next = wait_reg - 11'h001;
      end
      default:
        state_next = ST_RUN;
    endcase
    // run one cycle per ratio period
    cpu_next = (state_next == ST_RUN)
      && (!rr_next || ((phase_next & ratio_mask) == 8'h00));
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state_reg <= ST_RUN;
      halt_reg <= 1'b0;
      rr_reg <= REDUCED_RESET;
      roi_reg <= 1'b0;
      doe_reg <= 1'b0;
      ratio_reg <= RATIO_RESET;
      phase_reg <= PHASE_RESET;
      wait_reg <= 11'h000;
      pd_reg <= 1'b1;
      to_reg <= 1'b1;
      wdclr_reg <= 1'b0;
      wdrst_reg <= 1'b0;
      isr_reg <= 1'b0;
      isr_pend_reg <= 1'b0;
      hold_reg <= 8'h00;
      cpu_reg <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
      halt_reg <= halt_next;
      rr_reg <= rr_next;
      roi_reg <= roi_next;
      doe_reg <= doe_next;
      ratio_reg <= ratio_next;
      phase_reg <= phase_next;
      wait_reg <= wait_next;
      pd_reg <= pd_next;
      to_reg <= to_next;
      wdclr_reg <= wdclr_next;
      wdrst_reg <= wdrst_next;
      isr_reg <= isr_next;
      isr_pend_reg <= isr_pend_next;
      hold_reg <= hold_next;
      cpu_reg <= cpu_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  logic sys_reg, per_reg, cko_reg, reg_lp_reg, hold_en_reg;
  logic [1:0] mode_reg;

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      sys_reg <= 1'b1;
      per_reg <= 1'b1;
      cko_reg <= 1'b1;
      reg_lp_reg <= 1'b0;
      hold_en_reg <= 1'b0;
      mode_reg <= 2'h0;
    end
    else
    begin
      sys_reg <= (state_next != ST_SLEEP);
      per_reg <= (state_next != ST_SLEEP);
      cko_reg <= (state_next != ST_SLEEP);
      reg_lp_reg <= (state_next == ST_SLEEP)
        && regulator_lowpower_sel_i;
      hold_en_reg <= (state_next == ST_SLEEP);
      mode_reg <= (state_next == ST_SLEEP) ? 2'h2
        : (state_next == ST_IDLE) ? 2'h1 : 2'h0;
    end
  end

  assign cpu_run_o = cpu_reg;
  assign periph_clk_en_o = per_reg;
  assign sys_clk_en_o = sys_reg;
  assign clock_out_en_o = cko_reg;
  assign watchdog_clear_o = wdclr_reg;
  assign watchdog_reset_o = wdrst_reg;
  assign isr_branch_o = isr_reg;
  assign regulator_lowpower_o = reg_lp_reg;
  assign io_hold_o = hold_reg;
  assign io_hold_en_o = hold_en_reg;
  assign halt_select_o = halt_reg;
  assign reduced_rate_enable_o = rr_reg;
  assign recover_on_irq_o = roi_reg;
  assign resume_slow_on_exit_o = doe_reg;
  assign ratio_o = ratio_reg;
  assign powerdown_flag_o = pd_reg;
  assign watchdog_expired_flag_o = to_reg;
  assign mode_o = mode_reg;

  // ****************************************
  // checks
  // ****************************************
  // no input that moves the doze phase or the enable
  logic rate_quiet;

  assign rate_quiet = !ctrl_write_i && !irq_return_i && !irq_entry_i
    && !sleep_exec_i;

  hold_level_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == ST_SLEEP) |-> (io_hold_en_o && !clock_out_en_o))
    else $error("io hold off in sleep");
  isr_global_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == ST_SLEEP && irq_pending_i && !global_irq_enable_i)
    |=> !isr_pend_reg)
    else $error("isr armed with global off");
  osc_wait_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == ST_SLEEP && irq_pending_i && crystal_mode_i)
    |=> (wait_reg >= OSC_START_CYCLES))
    else $error("oscillator wait too short");
  sleep_flags_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == ST_RUN && sleep_exec_i && !irq_pending_i)
    |=> (!pd_reg && to_reg && wdclr_reg))
    else $error("sleep entry flags wrong");
  sleep_nop_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == ST_RUN && sleep_exec_i && irq_pending_i
     && !global_irq_enable_i)
    |=> (state_reg == ST_RUN && $stable(pd_reg) && !wdclr_reg))
    else $error("sleep not a no-op");
  sleep_select_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == ST_RUN && sleep_exec_i && !irq_pending_i
     && !ctrl_write_i)
    |=> (state_reg == (halt_reg ? ST_IDLE : ST_SLEEP)))
    else $error("wrong sleep mode");
  wake_clear_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    ((state_reg == ST_SLEEP || state_reg == ST_IDLE) && irq_pending_i)
    |=> wdclr_reg && state_reg == ST_WAKE)
    else $error("wake did not clear watchdog");
  sleep_clock_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    ($past(state_reg) == ST_SLEEP && state_reg == ST_SLEEP)
    |-> !sys_clk_en_o)
    else $error("clock runs in sleep");
  idle_periph_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == ST_IDLE) |-> (periph_clk_en_o && !cpu_run_o))
    else $error("idle clocks wrong");
  idle_wd_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == ST_IDLE && watchdog_timeout_i)
    |=> !watchdog_reset_o)
    else $error("watchdog reset in idle");
  entry_copy_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (irq_entry_i && !ctrl_write_i && !irq_return_i)
    |=> (doe_reg == $past(rr_reg)))
    else $error("resume bit not copied");
  exit_set_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (irq_return_i && !irq_entry_i && !ctrl_write_i)
    |=> (rr_reg == $past(doe_reg)))
    else $error("enable not restored");
  ratio_four_a: assert property (@(posedge mclk_i) disable iff (reset_i)
    (cpu_run_o && rr_reg && ratio_reg == 3'h1 && state_reg == ST_RUN
     && rate_quiet) ##1 rate_quiet [*2]
    |-> (!cpu_run_o && !$past(cpu_run_o)) ##1 !cpu_run_o)
    else $error("ratio 1:4 pattern wrong");
endmodule

// ### tb/irq_model.sv
`timescale 1ns/1ps
module irq_model
#(
  parameter int LAT = 20
)
(
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic isr_branch_i,
  output logic irq_entry_o,
  output logic irq_return_o
);
  int cnt_reg;
  int cnt_next;
  // ****************************************
  // cpu side: enter isr after branch, return LAT later
  // ****************************************
  always_comb
  begin
    cnt_next = cnt_reg;
    if (isr_branch_i)
      cnt_next = LAT;
    else if (cnt_reg != 0)
      cnt_next = cnt_reg - 1;
  end
  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      cnt_reg <= 0;
      irq_entry_o <= 1'b0;
      irq_return_o <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      irq_entry_o <= isr_branch_i;
      irq_return_o <= (cnt_reg == 1);
    end
  end
endmodule

// ### tb/power_mode_control_tb.sv
`timescale 1ns/1ps
module power_mode_control_tb;
  import power_mode_pkg::*;
  typedef struct {string nm; int sel; logic [31:0] ex;} note_s;
  logic mclk_i = 1'b0, reset_i = 1'b1, sleep_exec_i = 1'b0;
  logic irq_pending_i = 1'b0, global_irq_enable_i = 1'b0;
  logic irq_entry_i, irq_return_i, watchdog_timeout_i = 1'b0;
  logic crystal_mode_i = 1'b0, ctrl_write_i = 1'b0;
  logic halt_select_wr_i = 1'b0, reduced_rate_enable_wr_i = 1'b0;
  logic recover_on_irq_wr_i = 1'b0, resume_slow_on_exit_wr_i = 1'b0;
  logic [2:0] ratio_wr_i = 3'h0;
  logic regulator_lowpower_sel_i = 1'b0;
  logic [7:0] io_drive_i = 8'h00;
  logic cpu_run_o, periph_clk_en_o, sys_clk_en_o, clock_out_en_o;
  logic watchdog_clear_o, watchdog_reset_o, isr_branch_o;
  logic regulator_lowpower_o, io_hold_en_o, halt_select_o;
  logic reduced_rate_enable_o, recover_on_irq_o, resume_slow_on_exit_o;
  logic powerdown_flag_o, watchdog_expired_flag_o;
  logic [7:0] io_hold_o;
  logic [2:0] ratio_o;
  logic [1:0] mode_o;
  int n_mismatch = 0, n_checks = 0, cyc = 0, cnt, c1, c2;
  logic [31:0] meas, meas2, rnd = 32'h2;
  logic isr_seen, clr_seen;
  note_s q[$];
  note_s nt;
  power_mode_control dut_u (.mclk_i, .reset_i, .sleep_exec_i,
    .irq_pending_i, .global_irq_enable_i, .irq_entry_i, .irq_return_i,
    .watchdog_timeout_i, .crystal_mode_i, .ctrl_write_i,
    .halt_select_wr_i, .reduced_rate_enable_wr_i, .recover_on_irq_wr_i,
    .resume_slow_on_exit_wr_i, .ratio_wr_i, .regulator_lowpower_sel_i,
    .io_drive_i, .cpu_run_o, .periph_clk_en_o, .sys_clk_en_o,
    .clock_out_en_o, .watchdog_clear_o, .watchdog_reset_o, .isr_branch_o,
    .regulator_lowpower_o, .io_hold_o, .io_hold_en_o, .halt_select_o,
    .reduced_rate_enable_o, .recover_on_irq_o, .resume_slow_on_exit_o,
    .ratio_o, .powerdown_flag_o, .watchdog_expired_flag_o, .mode_o);
  irq_model #(.LAT(20)) cpu_u (.mclk_i, .reset_i,
    .isr_branch_i(isr_branch_o), .irq_entry_o(irq_entry_i),
    .irq_return_o(irq_return_i));
  always #10 mclk_i = ~mclk_i;
  function automatic logic [31:0] obs(int s);
    case (s)
      0: obs = 32'(mode_o);
      1: obs = 32'(powerdown_flag_o);
      2: obs = 32'(watchdog_expired_flag_o);
      3: obs = 32'(watchdog_clear_o);
      4: obs = 32'(sys_clk_en_o);
      5: obs = 32'(reduced_rate_enable_o);
      6: obs = 32'(resume_slow_on_exit_o);
      7: obs = 32'(io_hold_o);
      8: obs = 32'(cpu_run_o);
      9: obs = 32'(halt_select_o);
      10: obs = 32'(watchdog_reset_o);
      11: obs = meas;
      12: obs = meas2;
      13: obs = 32'(periph_clk_en_o & clock_out_en_o);
      15: obs = 32'(io_hold_en_o);
      16: obs = 32'(ratio_o);
      17: obs = 32'(recover_on_irq_o);
      default: obs = 32'(regulator_lowpower_o);
    endcase
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] ex);
    n_checks++;
    if (seen !== ex)
    begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", nm, ex, seen);
    end
  endtask
  function automatic logic [31:0] xs(logic [31:0] v);
    xs = v ^ (v << 13);
    xs = xs ^ (xs >> 17);
    xs = xs ^ (xs << 5);
  endfunction
  task automatic note(string nm, int s, logic [31:0] ex);
    q.push_back('{nm, s, ex});
  endtask
  // ****************************************
  // monitor: every queued note against the outputs
  // ****************************************
  always @(negedge mclk_i)
  begin
    while (q.size() > 0)
    begin
      nt = q.pop_front();
      chk(nt.nm, obs(nt.sel), nt.ex);
    end
  end
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_mismatch++;
      test_done();
    end
  end
  task automatic wr(logic h, logic e, logic r, logic s, logic [2:0] n);
    @(posedge mclk_i);
    ctrl_write_i <= 1'b1;
    halt_select_wr_i <= h;
    reduced_rate_enable_wr_i <= e;
    recover_on_irq_wr_i <= r;
    resume_slow_on_exit_wr_i <= s;
    ratio_wr_i <= n;
    @(posedge mclk_i);
    ctrl_write_i <= 1'b0;
  endtask
  task automatic do_sleep;
    @(posedge mclk_i);
    sleep_exec_i <= 1'b1;
    @(posedge mclk_i);
    sleep_exec_i <= 1'b0;
  endtask
  task automatic do_wdt;
    @(posedge mclk_i);
    watchdog_timeout_i <= 1'b1;
    @(posedge mclk_i);
    watchdog_timeout_i <= 1'b0;
  endtask
  task automatic wait_run;
    cnt = 0;
    isr_seen = 1'b0;
    clr_seen = 1'b0;
    while (cpu_run_o !== 1'b1 && cnt < 3000)
    begin
      @(negedge mclk_i);
      cnt++;
      clr_seen |= watchdog_clear_o;
      isr_seen |= isr_branch_o;
    end
    repeat (3)
    begin
      @(negedge mclk_i);
      isr_seen |= isr_branch_o;
    end
  endtask
  initial
  begin
    repeat (6) @(posedge mclk_i);
    reset_i <= 1'b0;
    note("mode", 0, 0);
    note("pd", 1, 1);
    note("to", 2, 1);
    for (int n = 0; n < 8; n++)
    begin
      wr(1'b0, 1'b1, 1'b0, 1'b0, 3'(n));
      note("first", 8, 1);
      c1 = 0;
      c2 = 0;
      repeat (2 << (n + 1))
      begin
        @(negedge mclk_i);
        c1 += int'(cpu_run_o === 1'b1);
        c2 += int'(periph_clk_en_o === 1'b1);
      end
      meas = 32'(c1);
      meas2 = 32'(c2 - (2 << (n + 1)));
      note("runs", 11, 2);
      note("periph", 12, 0);
    end
    $display("test doze done");
    for (int i = 0; i < 4; i++)
    begin
      rnd = xs(rnd);
      io_drive_i <= rnd[7:0];
      crystal_mode_i <= i[0];
      regulator_lowpower_sel_i <= i[1];
      global_irq_enable_i <= 1'b1;
      wr(1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
      do_sleep();
      note("mode", 0, 2);
      note("pd", 1, 0);
      note("to", 2, 1);
      note("wdclr", 3, 1);
      note("sysclk", 4, 0);
      note("iohold", 7, 32'(rnd[7:0]));
      note("holden", 15, 1);
      note("reglp", 14, 32'(i[1]));
      @(posedge mclk_i);
      irq_pending_i <= 1'b1;
      wait_run();
      c1 = (i[0] ? 1024 : 0) + (i[1] ? 100 : 0);
      meas = 32'(cnt >= c1 && cnt <= c1 + 6);
      note("waketime", 11, 1);
      meas2 = 32'({isr_seen, clr_seen});
      note("isr_clr", 12, 3);
      global_irq_enable_i <= 1'b0;
      do_sleep();
      note("noop", 0, 0);
      note("noclr", 3, 0);
      irq_pending_i <= 1'b0;
    end
    $display("test sleep done");
    crystal_mode_i <= 1'b0;
    regulator_lowpower_sel_i <= 1'b0;
    global_irq_enable_i <= 1'b1;
    for (int r = 0; r < 2; r++)
    begin
      wr(1'b0, 1'b1, r[0], 1'b0, 3'h1);
      note("ratio", 16, 1);
      note("roi", 17, 32'(r[0]));
      do_sleep();
      @(posedge mclk_i);
      irq_pending_i <= 1'b1;
      wait_run();
      irq_pending_i <= 1'b0;
      @(negedge mclk_i);
      note("en_isr", 5, 32'(!r[0]));
      note("resume", 6, 1);
      repeat (30) @(negedge mclk_i);
      note("en_ret", 5, 1);
    end
    $display("test irq done");
    global_irq_enable_i <= 1'b0;
    do_wdt();
    note("wdrst", 10, 1);
    wr(1'b1, 1'b1, 1'b1, 1'b0, 3'h0);
    do_sleep();
    note("idle", 0, 1);
    note("periph", 13, 1);
    @(negedge mclk_i);
    note("halted", 8, 0);
    do_wdt();
    note("nowdrst", 10, 0);
    wait_run();
    note("en_kept", 5, 1);
    do_sleep();
    note("reidle", 0, 1);
    @(posedge mclk_i);
    irq_pending_i <= 1'b1;
    wait_run();
    note("woke", 0, 0);
    note("halt", 9, 1);
    irq_pending_i <= 1'b0;
    $display("test idle done");
    repeat (3) @(negedge mclk_i);
    test_done();
  end
endmodule
